/* vcs_ctrl.sv */
// plug supply switch control, fault flags and error recovery
`include "vcs_cfg.svh"
`default_nettype none
module vcs_ctrl #(
  parameter int DIS_CYC = `VCS_DIS_MS * 1000 * `VCS_CLK_MHZ,
  parameter int ERR_CYC = `VCS_ERR_MS * 1000 * `VCS_CLK_MHZ
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] nvm_ilim,
  input wire logic nvm_discharge_en,
  input wire logic nvm_standby_en,
  input wire logic [1:0] sw_overcurrent,
  input wire logic [1:0] sw_overvolt,
  input wire logic [1:0] sw_reverse,
  input wire logic over_temp,
  input wire logic plug_supply_ok,
  input wire logic [1:0] ra_seen,
  input wire logic wired_cc2,
  input wire logic sink_valid,
  input wire logic conn_detect,
  input wire logic pullup_supply_ok,
  input wire logic cc_overvoltage,
  input wire logic bus_voltage_in_range,
  input wire logic supply_undervolt,
  input wire logic supply_overvolt,
  output logic [1:0] plug_switch_on,
  output logic uvlo_low_sel,
  output logic [3:0] ilim_code,
  output logic plug_discharge_on,
  output logic bus_discharge_on,
  output logic cc_term_on,
  output logic monitors_on,
  output logic bus_power_enable_out,
  output logic bus_power_enable_oe_n,
  output logic alert_n
);
  // ****************************************
  // parameter checks
  // ****************************************
  if (DIS_CYC < 1 || ERR_CYC < 1 || DIS_CYC >= 2**30 || ERR_CYC >= 2**30) begin : g_chk
    $error("vcs_ctrl: counts out of range");
  end

  localparam int CW = 30;
  localparam logic [CW-1:0] DIS_LD = CW'(DIS_CYC);
  localparam logic [CW-1:0] ERR_LD = CW'(ERR_CYC - 1);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [17:0] ain;
  logic [17:0] s1_r;
  logic [17:0] s2_r;
  assign ain = {sw_overcurrent, sw_overvolt, sw_reverse, over_temp, plug_supply_ok,
                ra_seen, wired_cc2, sink_valid, conn_detect, pullup_supply_ok,
                cc_overvoltage, bus_voltage_in_range, supply_undervolt, supply_overvolt};

  // reset to the no-fault levels: pull-up ok and bus in range read high,
  // since zeros here would fake a recovery trigger after every reset
  localparam logic [17:0] SYNC_IDLE = 18'h0_0014;

  // two stages per comparator, s1 feeds only s2
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= SYNC_IDLE;
      s2_r <= SYNC_IDLE;
    end else begin
      s1_r <= ain;
      s2_r <= s1_r;
    end
  end

  logic [1:0] ocp_s, ovp_s, rvp_s, ra_s;
  logic hot_s, pres_s, wired2_s, sink_s, conn_s, pu_s, ccov_s, bus_s, uv_s, ov_s;
  assign {ocp_s, ovp_s, rvp_s, hot_s, pres_s, ra_s, wired2_s, sink_s, conn_s,
          pu_s, ccov_s, bus_s, uv_s, ov_s} = s2_r;

  // ****************************************
  // control state
  // ****************************************
  vcs_pkg::vcs_state_e state_r, state_nxt;
  logic init_r, init_nxt;
  logic sby_r, sby_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [3:0] ilim_r, ilim_nxt;
  logic [CW-1:0] dis_r, dis_nxt;
  logic [CW-1:0] err_r, err_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic lost_r, lost_nxt;
  logic pres_d_r, pres_d_nxt;
  logic [1:0] sw_r, sw_nxt;
  logic oe_n_r, oe_n_nxt;
  logic alert_n_r, alert_n_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] fset;
  logic att, mon, err_trig, vdd_ok, rd_flags, rd_stat;

  // next values for the whole controller
  always_comb begin
    state_nxt = state_r;
    init_nxt = 1'b1;
    sby_nxt = sby_r;
    ctrl_nxt = ctrl_r;
    ilim_nxt = ilim_r;
    dis_nxt = (dis_r != '0) ? dis_r - CW'(1) : dis_r;
    err_nxt = err_r;
    att = (state_r == vcs_pkg::VCS_ATT);
    mon = (state_r != vcs_pkg::VCS_STANDBY); // monitors dark in standby
    vdd_ok = (ctrl_r[`VCS_CTRL_UVOFF] || !uv_s) && (ctrl_r[`VCS_CTRL_OVOFF] || !ov_s);
    // fault sources that force a detach
    err_trig = mon && (hot_s || !pu_s || ccov_s || (att && (!bus_s || !vdd_ok)));
    rd_flags = reg_re && (reg_addr == `VCS_OFS_FLAGS);
    rd_stat = reg_re && (reg_addr == `VCS_OFS_STAT);
    // start-up defaults come from config memory one cycle after release
    if (!init_r) begin
      ilim_nxt = (nvm_ilim > `VCS_ILIM_MAX) ? `VCS_ILIM_MAX : nvm_ilim;
      ctrl_nxt[`VCS_CTRL_DIS] = nvm_discharge_en;
      sby_nxt = nvm_standby_en;
      if (nvm_standby_en) begin
        state_nxt = vcs_pkg::VCS_STANDBY;
      end
    end else begin
      // software writes; limit code clamps so it never leaves the range
      if (reg_we && reg_addr == `VCS_OFS_CTRL) begin
        ctrl_nxt = reg_wdata & `VCS_CTRL_MASK;
      end
      if (reg_we && reg_addr == `VCS_OFS_ILIM) begin
        ilim_nxt = (reg_wdata[7:4] != 4'h0 || reg_wdata[3:0] > `VCS_ILIM_MAX) ?
                   `VCS_ILIM_MAX : reg_wdata[3:0];
      end
      unique case (state_r)
        vcs_pkg::VCS_STANDBY: begin
          if (conn_s) begin
            state_nxt = vcs_pkg::VCS_UNATT; // wake on connection
          end
        end
        vcs_pkg::VCS_UNATT: begin
          if (err_trig) begin
            state_nxt = vcs_pkg::VCS_ERR;
            err_nxt = ERR_LD;
          end else if (sink_s) begin
            state_nxt = vcs_pkg::VCS_ATT;
          end
        end
        vcs_pkg::VCS_ATT: begin
          if (err_trig) begin
            state_nxt = vcs_pkg::VCS_ERR;
            err_nxt = ERR_LD;
          end else if (!sink_s) begin
            dis_nxt = DIS_LD; // detach starts the discharge window
            state_nxt = sby_r ? vcs_pkg::VCS_STANDBY : vcs_pkg::VCS_UNATT;
          end
        end
        vcs_pkg::VCS_ERR: begin
          if (err_r != '0) begin
            err_nxt = err_r - CW'(1);
          end else if (!err_trig) begin
            // a trigger still present holds recovery, so a hot die stays off
            state_nxt = sby_r ? vcs_pkg::VCS_STANDBY : vcs_pkg::VCS_UNATT;
          end
        end
      endcase
    end
    // per-switch drive: only the unwired pin, all gates met
    for (int i = 0; i < 2; i++) begin
      sw_nxt[i] = ctrl_r[`VCS_CTRL_EN] && att && (wired2_s == (i == 0)) && ra_s[i] &&
                  pres_s && !hot_s && !ovp_s[i] && !rvp_s[i] && !err_trig;
    end
    // fault events; reverse only counts while the switch conducts
    fset = 8'h00;
    if (mon) begin
      fset[`VCS_FLG_OCP +: 2] = ocp_s;
      fset[`VCS_FLG_OVP +: 2] = ovp_s;
      fset[`VCS_FLG_RVP +: 2] = rvp_s & sw_r;
      fset[`VCS_FLG_HOT] = hot_s;
      fset[`VCS_FLG_CCOVP] = ccov_s;
    end
    // read clears, but a new event in the same cycle wins
    flags_nxt = (rd_flags ? 8'h00 : flags_r) | fset;
    pres_d_nxt = pres_s;
    lost_nxt = (rd_stat ? 1'b0 : lost_r) | (mon && pres_d_r && !pres_s);
    alert_n_nxt = !((|flags_nxt) || lost_nxt);
    oe_n_nxt = !(att && vdd_ok && bus_s && !err_trig);
    unique case (reg_addr)
      `VCS_OFS_CTRL: rdata_nxt = ctrl_r;
      `VCS_OFS_ILIM: rdata_nxt = {4'h0, ilim_r};
      `VCS_OFS_FLAGS: rdata_nxt = flags_r;
      `VCS_OFS_STAT: rdata_nxt = {2'b00, bus_s, pu_s, 2'(state_r), lost_r, pres_s};
      default: rdata_nxt = 8'h00;
    endcase
    if (!reg_re) begin
      rdata_nxt = 8'h00;
    end
  end

  // register stage for the whole controller
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= vcs_pkg::VCS_UNATT;
      init_r <= 1'b0;
      sby_r <= 1'b0;
      ctrl_r <= `VCS_CTRL_RST;
      ilim_r <= `VCS_ILIM_RST;
      dis_r <= '0;
      err_r <= '0;
      flags_r <= 8'h00;
      lost_r <= 1'b0;
      pres_d_r <= 1'b0;
      sw_r <= 2'b00;
      oe_n_r <= 1'b1;
      alert_n_r <= 1'b1;
      rdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      init_r <= init_nxt;
      sby_r <= sby_nxt;
      ctrl_r <= ctrl_nxt;
      ilim_r <= ilim_nxt;
      dis_r <= dis_nxt;
      err_r <= err_nxt;
      flags_r <= flags_nxt;
      lost_r <= lost_nxt;
      pres_d_r <= pres_d_nxt;
      sw_r <= sw_nxt;
      oe_n_r <= oe_n_nxt;
      alert_n_r <= alert_n_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // bus enable is open drain: pin held low, enable decides
  assign bus_power_enable_out = 1'b0;
  assign bus_power_enable_oe_n = oe_n_r;
  assign plug_switch_on = sw_r;
  assign uvlo_low_sel = ctrl_r[`VCS_CTRL_LOWUV]; // comparator level pick
  assign ilim_code = ilim_r;
  assign plug_discharge_on = (dis_r != '0) && ctrl_r[`VCS_CTRL_DIS];
  assign bus_discharge_on = (dis_r != '0) || (state_r == vcs_pkg::VCS_ERR);
  assign cc_term_on = (state_r != vcs_pkg::VCS_ERR);
  assign monitors_on = mon;
  assign alert_n = alert_n_r;
  assign reg_rdata = rdata_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_one_pin;
    !(plug_switch_on[0] && plug_switch_on[1]);
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("both pins supplied");

  property p_pin_gate;
    plug_switch_on[0] |-> $past(ra_s[0] && pres_s && wired2_s && att);
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin supplied off gate");

  property p_detach_dis;
    (att && !err_trig && !sink_s && init_r) |=> (dis_r == DIS_LD) ##1 (dis_r == DIS_LD - 1);
  endproperty
  a_detach_dis: assert property (p_detach_dis) else $error("discharge not started");

  property p_ilim_range;
    ilim_code <= `VCS_ILIM_MAX;
  endproperty
  a_ilim_range: assert property (p_ilim_range) else $error("limit code out of range");

  property p_ocp_alert;
    (mon && ocp_s[0]) |=> (flags_r[`VCS_FLG_OCP] && !alert_n);
  endproperty
  a_ocp_alert: assert property (p_ocp_alert) else $error("overcurrent not flagged");

  property p_hot;
    (mon && hot_s && init_r) |=> (state_r == vcs_pkg::VCS_ERR) && (plug_switch_on == 2'b00);
  endproperty
  a_hot: assert property (p_hot) else $error("thermal response missing");

  property p_err_pins;
    (state_r == vcs_pkg::VCS_ERR) |-> (!cc_term_on && bus_power_enable_oe_n && bus_discharge_on);
  endproperty
  a_err_pins: assert property (p_err_pins) else $error("recovery pins wrong");

  property p_sticky;
    (!rd_flags) |=> ((flags_r & $past(flags_r)) == $past(flags_r));
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost before read");

  property p_bus_en;
    !bus_power_enable_oe_n |-> $past(att && bus_s && vdd_ok);
  endproperty
  a_bus_en: assert property (p_bus_en) else $error("bus enable without attach");

  property p_standby;
    (att && !err_trig && !sink_s && sby_r && init_r) |=> (state_r == vcs_pkg::VCS_STANDBY);
  endproperty
  a_standby: assert property (p_standby) else $error("no standby after detach");
endmodule
`default_nettype wire

/* vcs_cfg.svh */
// constants for the plug supply switch and fault controller
`ifndef VCS_CFG_SVH
`define VCS_CFG_SVH
`define VCS_CLK_MHZ 100
`define VCS_DIS_MS 250
`define VCS_ERR_MS 25
`define VCS_OFS_CTRL 8'h00
`define VCS_OFS_ILIM 8'h04
`define VCS_OFS_FLAGS 8'h08
`define VCS_OFS_STAT 8'h0C
`define VCS_CTRL_EN 0
`define VCS_CTRL_LOWUV 1
`define VCS_CTRL_DIS 2
`define VCS_CTRL_UVOFF 3
`define VCS_CTRL_OVOFF 4
`define VCS_CTRL_MASK 8'h1F
`define VCS_CTRL_RST 8'h00
`define VCS_ILIM_RST 4'h0
`define VCS_ILIM_MAX 4'hA
`define VCS_FLG_OCP 0
`define VCS_FLG_OVP 2
`define VCS_FLG_RVP 4
`define VCS_FLG_HOT 6
`define VCS_FLG_CCOVP 7
`endif

/* vcs_pkg.sv */
// types for the plug supply switch and fault controller
`default_nettype none
package vcs_pkg;
  typedef enum logic [1:0] {
    VCS_STANDBY,
    VCS_UNATT,
    VCS_ATT,
    VCS_ERR
  } vcs_state_e;
endpackage
`default_nettype wire

/* vcs_partner.sv */
// far side model: a sink behind a cable that shows Ra on one pin
`default_nettype none
module vcs_partner (
  input wire logic clk,
  input wire logic plugged,
  input wire logic [1:0] ra_pin,
  output logic conn_detect,
  output logic sink_valid,
  output logic [1:0] ra_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] age_r;
  // contact shows before the sink settles, so standby wake can precede attach
  always_ff @(posedge clk) begin
    age_r <= plugged ? (age_r == 3'h7 ? age_r : age_r + 3'h1) : 3'h0;
  end
  // pins go quiet once unplugged, nothing lingers on them
  assign conn_detect = plugged;
  assign sink_valid = plugged && (age_r > 3'h3);
  assign ra_seen = plugged ? ra_pin : 2'h0;
endmodule
`default_nettype wire

/* test_vcs_ctrl.sv */
// self-checking bench for the plug supply switch controller
`default_nettype none
module test_vcs_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} vcs_row_s;
  // register rows: address, write data, read back
  localparam vcs_row_s ROWS [7] = '{'{8'h04, 8'h05, 8'h05}, '{8'h04, 8'h0B, 8'h0A},
    '{8'h04, 8'hF3, 8'h0A}, '{8'h04, 8'h00, 8'h00}, '{8'h10, 8'h55, 8'h00},
    '{8'h00, 8'hFF, 8'h1F}, '{8'h00, 8'h05, 8'h05}};
  localparam logic [7:0] FLG [5] = '{8'h40, 8'h00, 8'h80, 8'h00, 8'h00};
  logic clk = 1'h0, sys_rst = 1'h1, reg_we = 1'h0, reg_re = 1'h0, plugged = 1'h0;
  logic sb_en = 1'h0, dis_en = 1'h1, sup_ok = 1'h1, wired2 = 1'h1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd_v, reg_rdata;
  logic [5:0] swf = 6'h00;
  logic [4:0] trig = 5'h00;
  logic [3:0] ilim_code;
  logic [1:0] ra_pin = 2'h2, ra_seen, plug_switch_on;
  logic conn_detect, sink_valid, uvlo_low_sel, plug_discharge_on, bus_discharge_on;
  logic cc_term_on, monitors_on, bus_power_enable_oe_n, alert_n;
  int num_errors = 0, n_checks = 0, i;
  // short counts keep discharge and recovery windows quick to reach
  vcs_ctrl #(.DIS_CYC(20), .ERR_CYC(10)) vcs_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .nvm_ilim(4'hC), .nvm_discharge_en(dis_en),
    .nvm_standby_en(sb_en), .sw_overcurrent(swf[1:0]), .sw_overvolt(swf[3:2]),
    .sw_reverse(swf[5:4]), .over_temp(trig[0]), .plug_supply_ok(sup_ok),
    .ra_seen(ra_seen), .wired_cc2(wired2), .sink_valid(sink_valid),
    .conn_detect(conn_detect), .pullup_supply_ok(!trig[1]), .cc_overvoltage(trig[2]),
    .bus_voltage_in_range(!trig[3]), .supply_undervolt(trig[4]), .supply_overvolt(1'h0),
    .plug_switch_on(plug_switch_on), .uvlo_low_sel(uvlo_low_sel), .ilim_code(ilim_code),
    .plug_discharge_on(plug_discharge_on), .bus_discharge_on(bus_discharge_on),
    .cc_term_on(cc_term_on), .monitors_on(monitors_on), .bus_power_enable_out(),
    .bus_power_enable_oe_n(bus_power_enable_oe_n), .alert_n(alert_n));
  vcs_partner vcs_partner_inst (.clk(clk), .plugged(plugged), .ra_pin(ra_pin),
    .conn_detect(conn_detect), .sink_valid(sink_valid), .ra_seen(ra_seen));
  // free running 100 MHz clock
  always #5 clk = ~clk;
  // ****************************************
  // helper tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // sample 1 ns after the edge so that edge's updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'h1;
    @(posedge clk);
    reg_we <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'h1;
    @(posedge clk);
    reg_re <= 1'h0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic do_rst();
    @(posedge clk) sys_rst <= 1'h1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    cyc(3);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog: the sequence needs well under 5000 cycles
  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    do_rst();
    chk({ilim_code, uvlo_low_sel, bus_power_enable_oe_n, alert_n, monitors_on}, 8'hA7);
    $display("test reset done");
    for (i = 0; i < 7; i++) begin
      wr(ROWS[i].a, ROWS[i].d);
      rc(ROWS[i].a, ROWS[i].e);
      if (ROWS[i].a === 8'h04) chk({4'h0, ilim_code}, ROWS[i].e);
      if (ROWS[i].a === 8'h00) chk({7'h00, uvlo_low_sel}, {7'h00, ROWS[i].e[1]});
    end
    $display("test register rows done");
    // Ra on the wired pin must not get supply
    @(posedge clk) plugged <= 1'h1;
    cyc(12);
    chk({5'h00, plug_switch_on, bus_power_enable_oe_n}, 8'h00);
    @(posedge clk) ra_pin <= 2'h1;
    cyc(6);
    chk({5'h00, plug_switch_on, bus_power_enable_oe_n}, 8'h02);
    // orientation swap: CC1 now wired, Ra on CC2, so only CC2 is fed
    @(posedge clk) wired2 <= 1'h0;
    ra_pin <= 2'h2;
    cyc(6);
    chk({5'h00, plug_switch_on, bus_power_enable_oe_n}, 8'h04);
    @(posedge clk) wired2 <= 1'h1;
    ra_pin <= 2'h1;
    cyc(6);
    chk({5'h00, plug_switch_on, bus_power_enable_oe_n}, 8'h02);
    $display("test attach done");
    for (i = 0; i < 3; i++) begin
      @(posedge clk) swf <= 6'h01 << (2 * i);
      cyc(6);
      chk({alert_n, 7'h00}, 8'h00);
      if (i > 0) chk({6'h00, plug_switch_on}, 8'h00);
      @(posedge clk) swf <= 6'h00;
      cyc(6);
      rc(8'h08, 8'h01 << (2 * i));
      rc(8'h08, 8'h00);
      chk({alert_n, 5'h00, plug_switch_on}, 8'h81);
    end
    $display("test switch faults done");
    @(posedge clk) sup_ok <= 1'h0;
    cyc(6);
    chk({alert_n, 5'h00, plug_switch_on}, 8'h00);
    @(posedge clk) sup_ok <= 1'h1;
    cyc(6);
    rc(8'h0C, 8'h3B);
    rc(8'h0C, 8'h39);
    $display("test supply loss done");
    for (i = 0; i < 5; i++) begin
      @(posedge clk) trig <= 5'h01 << i;
      cyc(5);
      chk({cc_term_on, bus_power_enable_oe_n, bus_discharge_on, 5'h00}, 8'h60);
      chk({6'h00, plug_switch_on}, 8'h00);
      @(posedge clk) trig <= 5'h00;
      cyc(40);
      rc(8'h08, FLG[i]);
      chk({cc_term_on, bus_power_enable_oe_n, 4'h0, plug_switch_on}, 8'h81);
    end
    // supply undervolt detection switched off: no recovery, bus stays enabled
    wr(8'h00, 8'h0D);
    @(posedge clk) trig <= 5'h10;
    cyc(5);
    chk({cc_term_on, bus_power_enable_oe_n, 6'h00}, 8'h80);
    @(posedge clk) trig <= 5'h00;
    wr(8'h00, 8'h05);
    $display("test recovery done");
    @(posedge clk) plugged <= 1'h0;
    cyc(5);
    chk({plug_discharge_on, bus_discharge_on, 6'h00}, 8'hC0);
    cyc(25);
    chk({plug_discharge_on, bus_discharge_on, 6'h00}, 8'h00);
    $display("test detach done");
    @(posedge clk) sb_en <= 1'h1;
    dis_en <= 1'h0;
    do_rst();
    rc(8'h00, 8'h00);
    chk({monitors_on, 7'h00}, 8'h00);
    // faults are ignored while only connection detection runs
    @(posedge clk) trig <= 5'h01;
    cyc(6);
    chk({cc_term_on, 7'h00}, 8'h80);
    @(posedge clk) trig <= 5'h00;
    @(posedge clk) plugged <= 1'h1;
    cyc(8);
    chk({monitors_on, 7'h00}, 8'h80);
    @(posedge clk) plugged <= 1'h0;
    cyc(40);
    chk({monitors_on, 7'h00}, 8'h00);
    $display("test standby done");
    wrap_up();
  end
endmodule
`default_nettype wire
